// ---- hw/pawg_pkg.sv ----
// shared types and constants of the peripheral access wait generator
package pawg_pkg;

   // ----------------------------------------------------------------
   // register selection and instruction kinds
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PAWG_SEL_PLAIN    = 3'h0, // register that issues no wait
      PAWG_SEL_WDT_MODE = 3'h1, // watchdog_mode_reg
      PAWG_SEL_UART_RX  = 3'h2, // uart_rx_status_reg of uart_channel_zero
      PAWG_SEL_CONV_MOD = 3'h3, // converter_mode_reg
      PAWG_SEL_CONV_CH  = 3'h4, // converter_channel_select_reg
      PAWG_SEL_PF_MODE  = 3'h5, // power_fail_compare_mode_reg
      PAWG_SEL_PF_THR   = 3'h6, // power_fail_threshold_reg
      PAWG_SEL_CONV_RES = 3'h7  // conversion_result_reg
   } pawg_sel_t;

   typedef enum logic [1:0] {
      PAWG_OP_ACC_WR = 2'h0, // write from accumulator
      PAWG_OP_IMM_WR = 2'h1, // write of immediate operand
      PAWG_OP_ACC_RD = 2'h2  // read into accumulator
   } pawg_op_t;

   typedef struct packed {
      logic      we;    // write when high
      pawg_sel_t sel;   // target register
      pawg_op_t  op;    // instruction kind
      logic [7:0] wdata; // write data
   } pawg_req_t;

   // ----------------------------------------------------------------
   // wait and timing constants
   // ----------------------------------------------------------------
   localparam int unsigned CPU_CLK_NS     = 50;   // sys_clk period
   localparam int unsigned CPU_LOW_NS     = 50;   // cpu_clock_low_width of the table case
   localparam logic [4:0]  WDT_WAIT       = 5'h03;
   localparam logic [4:0]  UART_WAIT      = 5'h01;
   localparam logic [4:0]  RESULT_MIN     = 5'h01;
   localparam logic [4:0]  NO_WAIT        = 5'h00;
   localparam logic [4:0]  CALC_NO_WAIT   = 5'h01; // computed value that yields no stall
   localparam logic [4:0]  MACRO_DIV_SEL1 = 5'h02; // macro clock = input_clock_freq/2
   localparam logic [4:0]  MACRO_DIV_SEL0 = 5'h04; // macro clock = input_clock_freq/4
   localparam logic [2:0]  CPU_DIV_MAX    = 3'h4;  // cpu clock = input_clock_freq/16
   localparam logic [5:0]  BASE_ACC_WR    = 6'h05;
   localparam logic [5:0]  BASE_IMM_WR    = 6'h07;
   localparam logic [5:0]  BASE_ACC_RD    = 6'h05;
   localparam int unsigned CLK_SEL_BIT    = 5;     // converter_clock_select_bit position
   localparam logic        CLK_SEL_RESET  = 1'b0;

endpackage : pawg_pkg

// ---- hw/pawg_top.sv ----
// wait-state generator between cpu bus and slow peripheral bus
module pawg_top
#(
   parameter int unsigned WCW = 4 // width of peripheral_wait_control
) (
   input  wire logic             sys_clk,       // cpu clock
   input  wire logic             arst_n,        // async reset
   input  wire logic             req_valid,     // cpu access request
   input  wire pawg_pkg::pawg_req_t req,        // access description
   input  wire logic [2:0]       cpu_div,       // cpu clock divisor exponent
   input  wire logic [WCW-1:0]   wait_ctrl,     // peripheral_wait_control
   input  wire logic [7:0]       per_rdata,     // peripheral read data
   output logic                  cpu_stall_r,   // stall the cpu core
   output logic                  done_r,        // access complete pulse
   output logic [7:0]            rdata_r,       // data returned to cpu
   output logic                  per_wr_r,      // peripheral write pulse
   output pawg_pkg::pawg_sel_t   per_sel_r,     // peripheral register select
   output logic [7:0]            per_wdata_r,   // peripheral write data
   output logic [5:0]            exec_clocks_r, // instruction execution clocks
   output logic                  clk_sel_r      // converter_clock_select_bit shadow
);
   import pawg_pkg::*;

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PAWG_IDLE  = 3'b001,
      PAWG_STALL = 3'b010,
      PAWG_XFER  = 3'b100
   } pawg_state_t;

   pawg_state_t state_r, state_nxt;
   pawg_req_t   hold_r;
   logic [4:0]  cnt_r, cnt_nxt;
   logic [4:0]  acc_wait_r;

   // ----------------------------------------------------------------
   // wait calculation
   // ----------------------------------------------------------------
   // converter wait: twice the macro/cpu period ratio plus one, truncated
   function automatic logic [4:0] conv_wait(input logic sel, input logic [2:0] div);
      logic [4:0] mdiv;
      logic [2:0] d;
      logic [4:0] raw;
      mdiv = sel ? MACRO_DIV_SEL1 : MACRO_DIV_SEL0;
      d    = (div > CPU_DIV_MAX) ? CPU_DIV_MAX : div;
      raw  = 5'((mdiv << 1) >> d) + 5'h01;
      return (raw == CALC_NO_WAIT) ? NO_WAIT : raw;
   endfunction : conv_wait

   wire        take      = (state_r == PAWG_IDLE) && req_valid;
   wire        is_conv_w = req.we && (req.sel inside {PAWG_SEL_CONV_MOD, PAWG_SEL_CONV_CH,
                                                      PAWG_SEL_PF_MODE, PAWG_SEL_PF_THR});
   wire [4:0]  cw        = conv_wait(clk_sel_r, cpu_div);
   wire [4:0]  tab_wait  =
      (req.we && req.sel == PAWG_SEL_WDT_MODE)   ? WDT_WAIT :
      (!req.we && req.sel == PAWG_SEL_UART_RX)   ? UART_WAIT :
      is_conv_w                                  ? cw :
      (!req.we && req.sel == PAWG_SEL_CONV_RES)  ? ((cw == NO_WAIT) ? RESULT_MIN : cw) :
      NO_WAIT;
   // nonzero wait control stretches every waiting access further
   wire [4:0]  extra     = (tab_wait == NO_WAIT) ? NO_WAIT : 5'(wait_ctrl);
   wire [4:0]  wait_now  = 5'(tab_wait + extra);
   wire [5:0]  base_clk  = (req.op == PAWG_OP_IMM_WR) ? BASE_IMM_WR :
                           (req.op == PAWG_OP_ACC_WR) ? BASE_ACC_WR : BASE_ACC_RD;
   wire [5:0]  exec_now  = 6'(base_clk + 6'(wait_now));

   // access that completes at this edge: the fresh one or the held one
   wire        xfer_we   = take ? req.we : hold_r.we;
   wire        xfer_mode = take ? (req.sel == PAWG_SEL_CONV_MOD) : (hold_r.sel == PAWG_SEL_CONV_MOD);
   wire        xfer_fsel = take ? req.wdata[CLK_SEL_BIT] : hold_r.wdata[CLK_SEL_BIT];

   // ----------------------------------------------------------------
   // next-state decode
   // ----------------------------------------------------------------
   wire enter_xfer = (take && wait_now == NO_WAIT) ||
                     (state_r == PAWG_STALL && cnt_r == 5'h01);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         PAWG_IDLE: begin
            if (take) begin
               cnt_nxt   = wait_now;
               state_nxt = (wait_now == NO_WAIT) ? PAWG_XFER : PAWG_STALL;
            end
         end
         PAWG_STALL: begin
            // the held access waits here while the counter runs down to one
            cnt_nxt = 5'(cnt_r - 5'h01);
            if (cnt_r == 5'h01) begin
               state_nxt = PAWG_XFER;
            end
         end
         PAWG_XFER: begin
            state_nxt = PAWG_IDLE;
         end
         default: begin
            state_nxt = PAWG_IDLE;
            cnt_nxt   = 5'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // state and counter
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= PAWG_IDLE;
         cnt_r   <= 5'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // access capture at acceptance
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_r        <= '0;
         acc_wait_r    <= 5'h00;
         exec_clocks_r <= 6'h00;
         per_sel_r     <= PAWG_SEL_PLAIN;
         per_wdata_r   <= 8'h00;
      end else if (take) begin
         hold_r        <= req;
         acc_wait_r    <= wait_now;
         exec_clocks_r <= exec_now;
         per_sel_r     <= req.sel;
         per_wdata_r   <= req.wdata;
      end
   end

   // stall output: high exactly for the wait count
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_stall_r <= 1'b0;
      end else begin
         cpu_stall_r <= (state_nxt == PAWG_STALL);
      end
   end

   // transfer completion, data and clock select shadow
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         done_r    <= 1'b0;
         per_wr_r  <= 1'b0;
         rdata_r   <= 8'h00;
         clk_sel_r <= CLK_SEL_RESET;
      end else begin
         done_r   <= enter_xfer;
         per_wr_r <= enter_xfer && xfer_we;
         if (enter_xfer && !xfer_we) begin
            rdata_r <= per_rdata;
         end
         if (enter_xfer && xfer_we && xfer_mode) begin
            clk_sel_r <= xfer_fsel;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [4:0] run_r; // consecutive stall cycles seen
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= 5'h00;
      end else begin
         run_r <= cpu_stall_r ? 5'(run_r + 5'h01) : 5'h00;
      end
   end

   wire ctrl0 = (wait_ctrl == '0);

   stall_length_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $fell(cpu_stall_r) |-> run_r == acc_wait_r && done_r)
      else $error("stall length differs from computed wait");

   wdt_wait_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && req.we && req.sel == PAWG_SEL_WDT_MODE && req.op == PAWG_OP_ACC_WR
      |=> cpu_stall_r[*3] ##1 (!cpu_stall_r && done_r && exec_clocks_r == 6'h08))
      else $error("watchdog write wait wrong");

   wdt_imm_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && req.we && req.sel == PAWG_SEL_WDT_MODE && req.op == PAWG_OP_IMM_WR
      |=> exec_clocks_r == 6'h0a)
      else $error("immediate watchdog write clocks wrong");

   uart_wait_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && !req.we && req.sel == PAWG_SEL_UART_RX
      |=> cpu_stall_r ##1 (!cpu_stall_r && done_r && exec_clocks_r == 6'h06))
      else $error("uart status read wait wrong");

   plain_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && !req.we && req.sel == PAWG_SEL_PLAIN
      |=> !cpu_stall_r && done_r && exec_clocks_r == 6'h05)
      else $error("plain read not five clocks");

   conv_sel0_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && !clk_sel_r && cpu_div == 3'h0
      |=> cpu_stall_r[*4] ##1 cpu_stall_r[*5] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select zero");

   conv_sel1_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && clk_sel_r && cpu_div == 3'h1
      |=> cpu_stall_r[*3] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select one");

   no_wait_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && clk_sel_r && cpu_div == 3'h3
      |=> !cpu_stall_r && done_r)
      else $error("computed wait of one still stalled");

   result_min_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && !req.we && req.sel == PAWG_SEL_CONV_RES && cpu_div == 3'h4
      |=> cpu_stall_r ##1 (!cpu_stall_r && exec_clocks_r == 6'h06))
      else $error("result read lost its minimum wait");

   hold_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cpu_stall_r |-> !done_r && !per_wr_r)
      else $error("transfer during stall");

   clk_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      per_wr_r && per_sel_r == PAWG_SEL_CONV_MOD |-> clk_sel_r == per_wdata_r[CLK_SEL_BIT])
      else $error("clock select shadow not updated");

   conv_s0_div1_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && !clk_sel_r && cpu_div == 3'h1
      |=> cpu_stall_r[*5] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select zero half rate");

   conv_s0_div2_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && !clk_sel_r && cpu_div == 3'h2
      |=> cpu_stall_r[*3] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select zero quarter rate");

   conv_s0_div3_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && !clk_sel_r && cpu_div == 3'h3
      |=> cpu_stall_r[*2] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select zero eighth rate");

   conv_s0_div4_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && !clk_sel_r && cpu_div == 3'h4
      |=> !cpu_stall_r && done_r)
      else $error("converter write stalled at select zero slowest rate");

   conv_s1_div0_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && clk_sel_r && cpu_div == 3'h0
      |=> cpu_stall_r[*5] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select one full rate");

   conv_s1_div2_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && clk_sel_r && cpu_div == 3'h2
      |=> cpu_stall_r[*2] ##1 !cpu_stall_r)
      else $error("converter write wait wrong at select one quarter rate");

   conv_s1_div4_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && is_conv_w && clk_sel_r && cpu_div == 3'h4
      |=> !cpu_stall_r && done_r)
      else $error("converter write stalled at select one slowest rate");

   result_s0_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && !req.we && req.sel == PAWG_SEL_CONV_RES && !clk_sel_r && cpu_div == 3'h0
      |=> exec_clocks_r == 6'h0e ##8 cpu_stall_r ##1 (!cpu_stall_r && done_r))
      else $error("result read wait wrong at select zero");

   result_s1_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && ctrl0 && !req.we && req.sel == PAWG_SEL_CONV_RES && clk_sel_r && cpu_div == 3'h0
      |=> exec_clocks_r == 6'h0a ##4 cpu_stall_r ##1 (!cpu_stall_r && done_r))
      else $error("result read wait wrong at select one");

   done_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      done_r |=> !done_r)
      else $error("completion pulse longer than one cycle");

   busy_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (cpu_stall_r || done_r) |=> $stable(exec_clocks_r) && $stable(per_wdata_r))
      else $error("access replaced while busy");

   wctrl_stretch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && req.we && req.sel == PAWG_SEL_WDT_MODE
      |=> acc_wait_r == 5'(WDT_WAIT + 5'($past(wait_ctrl))))
      else $error("wait control not added to watchdog wait");

   plain_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      take && req.we && req.sel == PAWG_SEL_PLAIN && req.op == PAWG_OP_IMM_WR
      |=> !cpu_stall_r && done_r && per_wr_r && exec_clocks_r == 6'h07)
      else $error("plain immediate write not seven clocks");

   read_capture_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      done_r && !per_wr_r |-> rdata_r == $past(per_rdata))
      else $error("read data not taken at end of wait");

endmodule : pawg_top

// ---- tb/pawg_cpu_model.sv ----
// cpu core model that issues single accesses and counts stall cycles
module pawg_cpu_model
(
   input  wire logic                sys_clk,     // cpu clock
   input  wire logic                cpu_stall_r, // stall from the block
   input  wire logic                done_r,      // access complete pulse
   output pawg_pkg::pawg_req_t      req,         // access description
   output logic                     req_valid,   // access request
   output logic [2:0]               cpu_div,     // divisor exponent
   output logic [3:0]               wait_ctrl    // wait control
);
   timeunit 1ns;
   timeprecision 1ns;
   import pawg_pkg::*;

   // idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req       = '0;
      cpu_div   = 3'h0;
      wait_ctrl = 4'h0;
   end

   // one access: held up to the taking edge, then released with inverted data
   task automatic access(input pawg_req_t r, input logic [2:0] d, input logic [3:0] w,
                         output int stalls, output logic ok);
      stalls = 0;
      ok     = 1'b0;
      @(posedge sys_clk);
      #1;
      req       = r;
      cpu_div   = d;
      wait_ctrl = w;
      req_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
      req       = pawg_req_t'(~r);
      cpu_div   = ~d;
      wait_ctrl = ~w;
      // core holds its state while stalled, bounded wait for completion
      for (int n = 0; n < 40; n++) begin
         if (done_r === 1'b1) begin
            ok = 1'b1;
            break;
         end
         if (cpu_stall_r === 1'b1) begin
            stalls++;
         end
         @(posedge sys_clk);
         #1;
      end
   endtask : access
endmodule : pawg_cpu_model

// ---- tb/tb_top.sv ----
// self-checking bench of the peripheral access wait generator
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pawg_pkg::*;
   logic       sys_clk;
   logic       arst_n;
   logic       req_valid;
   pawg_req_t  req;
   logic [2:0] cpu_div;
   logic [3:0] wait_ctrl;
   logic [7:0] per_rdata;
   logic       cpu_stall_r;
   logic       done_r;
   logic [7:0] rdata_r;
   logic       per_wr_r;
   pawg_sel_t  per_sel_r;
   logic [7:0] per_wdata_r;
   logic [5:0] exec_clocks_r;
   logic       clk_sel_r;
   int         mismatches = 0;
   int         n_checks = 0;

   pawg_top #(.WCW(4)) i_pawg_top (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
      .cpu_div(cpu_div), .wait_ctrl(wait_ctrl), .per_rdata(per_rdata), .cpu_stall_r(cpu_stall_r),
      .done_r(done_r), .rdata_r(rdata_r), .per_wr_r(per_wr_r), .per_sel_r(per_sel_r),
      .per_wdata_r(per_wdata_r), .exec_clocks_r(exec_clocks_r), .clk_sel_r(clk_sel_r));
   pawg_cpu_model i_pawg_cpu_model (.sys_clk(sys_clk), .cpu_stall_r(cpu_stall_r), .done_r(done_r),
      .req(req), .req_valid(req_valid), .cpu_div(cpu_div), .wait_ctrl(wait_ctrl));

   // ----------------------------------------------------------------
   // compare and access helpers
   // ----------------------------------------------------------------
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_cnt(input int got, input int exp, input string what);
      n_checks++;
      if (got != exp) begin
         mismatches++;
         $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask : chk_cnt

   // runs one access and judges stall count, execution clocks and data
   task automatic acc(input pawg_sel_t s, input logic we, input pawg_op_t op, input logic [2:0] d,
                      input logic [3:0] w, input logic [7:0] wd, input int ew);
      int         st;
      logic       ok;
      logic [5:0] base;
      base      = (op == PAWG_OP_IMM_WR) ? BASE_IMM_WR :
                  (op == PAWG_OP_ACC_WR) ? BASE_ACC_WR : BASE_ACC_RD;
      per_rdata = ~per_rdata;
      i_pawg_cpu_model.access('{we: we, sel: s, op: op, wdata: wd}, d, w, st, ok);
      if (!ok) begin
         chk_val(8'h00, 8'h01, "no completion");
         close_out();
      end
      chk_cnt(st, ew, "stall cycles");
      chk_val({2'h0, exec_clocks_r}, {2'h0, base + 6'(ew)}, "execution clocks");
      chk_val({7'h0, per_wr_r}, {7'h0, we}, "write strobe");
      chk_val({5'h0, per_sel_r}, {5'h0, s}, "register select");
      chk_val(we ? per_wdata_r : rdata_r, we ? wd : per_rdata, "data");
   endtask : acc

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_fixed;
      acc(PAWG_SEL_PLAIN, 1'b0, PAWG_OP_ACC_RD, 3'h0, 4'h0, 8'h00, 0);
      acc(PAWG_SEL_PLAIN, 1'b1, PAWG_OP_IMM_WR, 3'h0, 4'h0, 8'h3c, 0);
      acc(PAWG_SEL_WDT_MODE, 1'b1, PAWG_OP_ACC_WR, 3'h0, 4'h0, 8'h5a, 3);
      acc(PAWG_SEL_WDT_MODE, 1'b1, PAWG_OP_IMM_WR, 3'h2, 4'h0, 8'ha5, 3);
      acc(PAWG_SEL_UART_RX, 1'b0, PAWG_OP_ACC_RD, 3'h4, 4'h0, 8'h00, 1);
      $display("test fixed waits done");
   endtask : t_fixed

   task automatic t_conv;
      int         tab [2][5] = '{'{9, 5, 3, 2, 0}, '{5, 3, 2, 0, 0}};
      logic [7:0] wd;
      int         rd_w;
      for (int fs = 0; fs < 2; fs++) begin
         wd = {2'h0, 1'(fs), 5'h0a};
         acc(PAWG_SEL_CONV_MOD, 1'b1, PAWG_OP_ACC_WR, 3'h4, 4'h0, wd, 0);
         @(posedge sys_clk);
         #1;
         chk_val({7'h0, clk_sel_r}, 8'(fs), "clock select shadow");
         for (int d = 0; d < 5; d++) begin
            for (int s = 3; s < 7; s++) begin
               acc(pawg_sel_t'(s), 1'b1, PAWG_OP_ACC_WR, 3'(d), 4'h0, wd, tab[fs][d]);
            end
            rd_w = (tab[fs][d] == 0) ? 1 : tab[fs][d];
            acc(PAWG_SEL_CONV_RES, 1'b0, PAWG_OP_ACC_RD, 3'(d), 4'h0, 8'h00, rd_w);
         end
      end
      $display("test converter waits done");
   endtask : t_conv

   task automatic t_wctrl;
      acc(PAWG_SEL_WDT_MODE, 1'b1, PAWG_OP_ACC_WR, 3'h0, 4'h2, 8'h11, 5);
      acc(PAWG_SEL_PLAIN, 1'b0, PAWG_OP_ACC_RD, 3'h0, 4'h2, 8'h00, 0);
      $display("test wait control done");
   endtask : t_wctrl

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   // clock generation
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // main sequence
   initial begin
      arst_n    = 1'b0;
      per_rdata = 8'h96;
      repeat (16) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      chk_val({6'h0, cpu_stall_r, done_r}, 8'h00, "idle after reset");
      t_fixed();
      t_conv();
      t_wctrl();
      close_out();
   end
endmodule : tb_top
